// ===== hw/frm_pkg.sv
// constants, states and carrier types of the flash rewrite monitor
package frm_pkg;

  // serial link timing
  localparam int CLK_HZ      = 50_000_000;                // system clock rate
  localparam int BAUD_BPS    = 38400;                     // link bit rate
  localparam int BIT_CYCLES  = CLK_HZ / BAUD_BPS;         // clocks per bit
  localparam int HALF_CYCLES = BIT_CYCLES / 2;            // clocks to mid bit
  localparam int BCNT_W      = 11;                        // bit timer width
  localparam logic [BCNT_W-1:0] BIT_LAST  = BCNT_W'(BIT_CYCLES - 1);
  localparam logic [BCNT_W-1:0] HALF_LAST = BCNT_W'(HALF_CYCLES - 1);
  localparam logic [3:0]        DATA_BITS = 4'h8;         // bits per character

  // packet handling
  localparam int REC_SIZE = 256;                          // bytes per record
  localparam logic [8:0]  REC_LEN  = 9'h100;              // record as count
  localparam logic [7:0]  REC_LAST = 8'hFF;               // last record index
  localparam logic [7:0]  PAD_BYTE = 8'hFF;               // filler for short packet

  // command strings and replies
  localparam logic [23:0] CMD_PRG  = 24'h707267;          // "prg"
  localparam logic [23:0] CMD_ERS  = 24'h657273;          // "ers"
  localparam logic [23:0] CMD_RUN  = 24'h72756E;          // "run"
  localparam logic [7:0]  REPLY_OK = 8'h6F;               // 'o'
  localparam logic [7:0]  REPLY_ER = 8'h65;               // 'e'

  // control bits
  localparam logic [7:0]  SUBMODE_RST = 8'h00;            // sub-mode reg reset
  localparam int          SUBMODE_SEL = 0;                // select bit position

  // address map
  localparam int          ADDR_W     = 20;
  localparam logic [19:0] DFLASH_LO  = 20'h0E000;
  localparam logic [19:0] DFLASH_HI  = 20'h0FFFF;
  localparam logic [19:0] UROM_LO    = 20'h40000;
  localparam logic [19:0] UROM_HI    = 20'h7FFFF;
  localparam logic [19:0] SEC_BASE   = 20'h10000;         // secondary area start

  // monitor states
  typedef enum logic [3:0] {
    ST_CMD   = 4'h0,
    ST_SIZE  = 4'h1,
    ST_DATA  = 4'h2,
    ST_SUM   = 4'h3,
    ST_CHECK = 4'h4,
    ST_PROG  = 4'h5,
    ST_PWAIT = 4'h6,
    ST_ERASE = 4'h7,
    ST_EWAIT = 4'h8,
    ST_REPLY = 4'h9
  } frm_state_t;

  // mode bits seen by the processor
  typedef struct packed {
    logic rewrite_mode;
    logic running_submode;
    logic data_flash_enable;
    logic expanded_space_bit;
  } frm_mode_t;

  // request toward the flash array
  typedef struct packed {
    logic              prog;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } frm_flash_req_t;

  // operation status
  typedef struct packed {
    logic busy;
    logic done_ok;
    logic done_err;
  } frm_status_t;

endpackage : frm_pkg

// ===== hw/frm_uart.sv
// 8N1 serial receiver and transmitter for the monitor link
`timescale 1ns/1ps
module frm_uart (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       rx_in,
  output logic            tx_out,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  input  wire logic       tx_start_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_busy_out
);
  import frm_pkg::*;

  logic [BCNT_W-1:0] rx_tmr_q;   // receive bit timer
  logic [3:0]        rx_bit_q;   // receive bit index
  logic              rx_act_q;   // frame in progress
  logic [7:0]        rx_sh_q;    // receive shift
  logic [BCNT_W-1:0] tx_tmr_q;   // transmit bit timer
  logic [3:0]        tx_bit_q;   // transmit bit index
  logic [9:0]        tx_sh_q;    // stop, data, start

  // receiver: start edge, mid-bit sampling, stop bit must be high
  always_ff @(posedge clk_in) begin
    rx_valid_out <= 1'b0;
    if (sys_rst_in) begin
      rx_act_q    <= 1'b0;
      rx_tmr_q    <= '0;
      rx_bit_q    <= '0;
      rx_sh_q     <= '0;
      rx_data_out <= '0;
    end else if (!rx_act_q) begin
      // idle: wait for start bit, then go to its middle
      if (!rx_in) begin
        rx_act_q <= 1'b1;
        rx_tmr_q <= HALF_LAST;
        rx_bit_q <= '0;
      end
    end else if (rx_tmr_q != '0) begin
      rx_tmr_q <= rx_tmr_q - 1'b1;
    end else begin
      rx_tmr_q <= BIT_LAST;
      if (rx_bit_q == '0) begin
        // glitch on start bit drops the frame
        rx_act_q <= ~rx_in;
        rx_bit_q <= 4'h1;
      end else if (rx_bit_q <= DATA_BITS) begin
        rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
        rx_bit_q <= rx_bit_q + 1'b1;
      end else begin
        // stop bit: framing error discards the byte
        rx_act_q     <= 1'b0;
        rx_valid_out <= rx_in;
        rx_data_out  <= rx_sh_q;
      end
    end
  end

  // transmitter: ten bits lsb first, line idles high
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      tx_sh_q     <= '1;
      tx_tmr_q    <= '0;
      tx_bit_q    <= '0;
      tx_busy_out <= 1'b0;
      tx_out      <= 1'b1;
    end else if (!tx_busy_out) begin
      if (tx_start_in) begin
        tx_sh_q     <= {1'b1, tx_data_in, 1'b0};
        tx_busy_out <= 1'b1;
        tx_tmr_q    <= BIT_LAST;
        tx_bit_q    <= '0;
        tx_out      <= 1'b0;
      end
    end else if (tx_tmr_q != '0) begin
      tx_tmr_q <= tx_tmr_q - 1'b1;
    end else if (tx_bit_q == 4'h9) begin
      tx_busy_out <= 1'b0;
      tx_out      <= 1'b1;
    end else begin
      tx_tmr_q <= BIT_LAST;
      tx_bit_q <= tx_bit_q + 1'b1;
      tx_out   <= tx_sh_q[tx_bit_q + 1'b1];
    end
  end

endmodule : frm_uart

// ===== hw/frm_monitor.sv
// flash rewrite monitor: serial command interpreter and rewrite mode control
//
// How it works
// - flash commands only after rewrite enable set
// - sub-mode bit 0 selects running rewrite
// - processor keeps running during running-mode operations
// - interrupts taken only with vector, handler in RAM
// - rewrite mode forces data-flash and expansion bits
// - status shows each operation's success or failure
// - locked blocks refuse program and erase
// - upper blocks need large part and enable
// - secondary area usable only while control bit 0
// - data flash mapped only while enable is 1
// - reply 6Fh on success, 65h on error
// - link is 38400 bps 8N1, no flow control
// - two size bytes precede packet data
// - packets up to 256 bytes, one buffered
// - two checksum bytes compared, error on mismatch
// - slow clock, program packet, restore clock
// - write failure replies error and stops transfer
// - repeat packets until announced size received
// - erase with slowed clock, then reply
// - run command jumps to secondary program
// - short packet padded with FFh before programming
`timescale 1ns/1ps
module frm_monitor (
  input  wire logic                    clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic                    serial_rx_in,
  output logic                         serial_tx_out,
  input  wire logic                    rewrite_enable_bit_in,
  input  wire logic                    submode_write_unlock_in,
  input  wire logic                    submode_wr_in,
  input  wire logic [7:0]              submode_wdata_in,
  input  wire logic                    pm_data_flash_in,
  input  wire logic                    pm_expanded_in,
  input  wire logic                    rom1_large_in,
  input  wire logic                    upper_rom_enable_in,
  input  wire logic                    secondary_rom_disable_in,
  input  wire logic                    secondary_lock_in,
  input  wire logic [frm_pkg::ADDR_W-1:0] cpu_addr_in,
  input  wire logic                    periph_irq_in,
  input  wire logic                    vector_in_ram_in,
  input  wire logic                    handler_in_ram_in,
  input  wire logic                    flash_done_in,
  input  wire logic                    flash_fail_in,
  output frm_pkg::frm_mode_t           mode_out,
  output frm_pkg::frm_status_t         status_out,
  output frm_pkg::frm_flash_req_t      flash_req_out,
  output logic [7:0]                   flash_submode_reg_out,
  output logic                         cpu_hold_out,
  output logic                         cpu_slow_out,
  output logic                         irq_take_out,
  output logic                         run_req_out,
  output logic                         data_flash_sel_out,
  output logic                         upper_rom_sel_out,
  output logic                         secondary_map_out
);
  import frm_pkg::*;

  // address window test used by both map decoders
  function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // serial side wires
  logic       rx_valid;        // one received byte
  logic [7:0] rx_data;         // its value
  logic       tx_busy;         // transmitter occupied
  logic       tx_start_q;      // send request pulse
  logic [7:0] tx_byte_q;       // byte to send

  // monitor state
  frm_state_t  state_q;        // current state
  frm_state_t  ret_q;          // state after reply
  logic [23:0] cmd_q;          // last three characters
  logic [1:0]  cmd_cnt_q;      // characters held
  logic        hi_byte_q;      // first of a byte pair seen
  logic [15:0] remain_q;       // bytes still announced
  logic [8:0]  pkt_len_q;      // bytes in current packet
  logic [8:0]  cnt_q;          // byte index
  logic [15:0] sum_q;          // computed checksum
  logic [15:0] rsum_q;         // received checksum
  logic [15:0] woff_q;         // offset into secondary area
  logic [7:0]  buf_q [REC_SIZE];  // one packet record

  // control register state
  logic        rewrite_mode_q;      // rewrite mode entered
  logic [7:0]  submode_q;           // sub-mode register

  // decoding of command and operation conditions
  wire        is_prg     = (cmd_q == CMD_PRG);
  wire        is_ers     = (cmd_q == CMD_ERS);
  wire        is_run     = (cmd_q == CMD_RUN);
  wire        running    = ~submode_q[SUBMODE_SEL];
  wire        may_write  = rewrite_mode_q & ~secondary_lock_in
                           & ~secondary_rom_disable_in;
  wire [8:0]  next_len   = (remain_q >= 16'(REC_LEN)) ? REC_LEN : remain_q[8:0];
  wire [7:0]  prog_byte  = (cnt_q < pkt_len_q) ? buf_q[cnt_q[7:0]] : PAD_BYTE;
  wire [15:0] remain_nx  = remain_q - 16'(pkt_len_q);
  wire        df_mode    = rewrite_mode_q | pm_data_flash_in;
  wire        exp_mode   = rewrite_mode_q | pm_expanded_in;

  // serial link, 8N1 at the configured rate
  frm_uart u_uart (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .rx_in        (serial_rx_in),
    .tx_out       (serial_tx_out),
    .rx_valid_out (rx_valid),
    .rx_data_out  (rx_data),
    .tx_start_in  (tx_start_q),
    .tx_data_in   (tx_byte_q),
    .tx_busy_out  (tx_busy)
  );

  // rewrite enable and guarded sub-mode register
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rewrite_mode_q <= 1'b0;
      submode_q      <= SUBMODE_RST;
    end else begin
      rewrite_mode_q <= rewrite_enable_bit_in;
      // written only while unlock bit is set
      if (submode_wr_in && submode_write_unlock_in) begin
        submode_q <= submode_wdata_in;
      end
    end
  end

  // mode bits, address maps and interrupt gate, all registered
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_out              <= '0;
      flash_submode_reg_out <= SUBMODE_RST;
      cpu_hold_out          <= 1'b0;
      irq_take_out          <= 1'b0;
      data_flash_sel_out    <= 1'b0;
      upper_rom_sel_out     <= 1'b0;
      secondary_map_out     <= 1'b0;
    end else begin
      mode_out.rewrite_mode       <= rewrite_mode_q;
      mode_out.running_submode    <= rewrite_mode_q & running;
      mode_out.data_flash_enable  <= df_mode;
      mode_out.expanded_space_bit <= exp_mode;
      flash_submode_reg_out       <= submode_q;
      // other sub-mode stalls the processor while busy
      cpu_hold_out       <= status_out.busy & ~running;
      irq_take_out       <= periph_irq_in & vector_in_ram_in
                            & handler_in_ram_in;
      data_flash_sel_out <= df_mode & in_range(cpu_addr_in, DFLASH_LO, DFLASH_HI);
      upper_rom_sel_out  <= rom1_large_in & upper_rom_enable_in
                            & in_range(cpu_addr_in, UROM_LO, UROM_HI);
      secondary_map_out  <= ~secondary_rom_disable_in;
    end
  end

  // packet buffer write port
  always_ff @(posedge clk_in) begin
    if (state_q == ST_DATA && rx_valid) begin
      buf_q[cnt_q[7:0]] <= rx_data;
    end
  end

  // command interpreter
  always_ff @(posedge clk_in) begin
    tx_start_q        <= 1'b0;
    run_req_out       <= 1'b0;
    flash_req_out.prog  <= 1'b0;
    flash_req_out.erase <= 1'b0;
    if (sys_rst_in) begin
      state_q       <= ST_CMD;
      ret_q         <= ST_CMD;
      cmd_q         <= '0;
      cmd_cnt_q     <= '0;
      hi_byte_q     <= 1'b0;
      remain_q      <= '0;
      pkt_len_q     <= '0;
      cnt_q         <= '0;
      sum_q         <= '0;
      rsum_q        <= '0;
      woff_q        <= '0;
      tx_byte_q     <= '0;
      cpu_slow_out  <= 1'b0;
      status_out    <= '0;
      flash_req_out <= '0;
    end else begin
      case (state_q)
        // collect three characters, then decode
        ST_CMD: begin
          if (rx_valid) begin
            cmd_q     <= {cmd_q[15:0], rx_data};
            cmd_cnt_q <= (cmd_cnt_q == 2'h2) ? 2'h0 : cmd_cnt_q + 1'b1;
          end
          if (cmd_cnt_q == 2'h0 && cmd_q != '0) begin
            cmd_q <= '0;
            if (is_prg) begin
              state_q   <= ST_SIZE;
              hi_byte_q <= 1'b0;
              woff_q    <= '0;
            end else if (is_ers) begin
              cpu_slow_out <= 1'b1;
              state_q      <= ST_ERASE;
            end else if (is_run) begin
              run_req_out <= 1'b1;
            end else begin
              // unknown string: error reply, back to wait
              tx_byte_q <= REPLY_ER;
              ret_q     <= ST_CMD;
              state_q   <= ST_REPLY;
            end
          end
        end
        // two size bytes, high byte first
        ST_SIZE: begin
          if (rx_valid) begin
            remain_q  <= {remain_q[7:0], rx_data};
            hi_byte_q <= ~hi_byte_q;
            if (hi_byte_q) begin
              state_q <= ST_DATA;
              cnt_q   <= '0;
              sum_q   <= '0;
            end
          end
          if (state_q == ST_DATA) begin
            pkt_len_q <= next_len;
          end
        end
        // packet bytes into the buffer with running sum
        ST_DATA: begin
          if (remain_q == '0) begin
            state_q <= ST_CMD;
          end else begin
            pkt_len_q <= next_len;
            if (rx_valid) begin
              sum_q <= sum_q + 16'(rx_data);
              cnt_q <= cnt_q + 1'b1;
              if (cnt_q + 1'b1 == next_len) begin
                state_q   <= ST_SUM;
                hi_byte_q <= 1'b0;
              end
            end
          end
        end
        // two checksum bytes, high byte first
        ST_SUM: begin
          if (rx_valid) begin
            rsum_q    <= {rsum_q[7:0], rx_data};
            hi_byte_q <= ~hi_byte_q;
            if (hi_byte_q) begin
              state_q <= ST_CHECK;
            end
          end
        end
        // compare sums; on match slow the clock and program
        ST_CHECK: begin
          cnt_q <= '0;
          if (rsum_q != sum_q) begin
            tx_byte_q <= REPLY_ER;
            ret_q     <= ST_CMD;
            state_q   <= ST_REPLY;
          end else begin
            cpu_slow_out      <= 1'b1;
            status_out        <= '{busy: 1'b1, done_ok: 1'b0, done_err: 1'b0};
            state_q           <= ST_PROG;
          end
        end
        // issue one byte of the full record
        ST_PROG: begin
          if (!may_write) begin
            cpu_slow_out <= 1'b0;
            status_out   <= '{busy: 1'b0, done_ok: 1'b0, done_err: 1'b1};
            tx_byte_q    <= REPLY_ER;
            ret_q        <= ST_CMD;
            state_q      <= ST_REPLY;
          end else begin
            flash_req_out.prog <= 1'b1;
            flash_req_out.addr <= SEC_BASE + ADDR_W'(woff_q) + ADDR_W'(cnt_q);
            flash_req_out.data <= prog_byte;
            state_q            <= ST_PWAIT;
          end
        end
        // wait for the array, stop transfer on failure
        ST_PWAIT: begin
          if (flash_done_in) begin
            if (flash_fail_in) begin
              cpu_slow_out <= 1'b0;
              status_out   <= '{busy: 1'b0, done_ok: 1'b0, done_err: 1'b1};
              tx_byte_q    <= REPLY_ER;
              ret_q        <= ST_CMD;
              state_q      <= ST_REPLY;
            end else if (cnt_q[7:0] == REC_LAST) begin
              cpu_slow_out <= 1'b0;
              status_out   <= '{busy: 1'b0, done_ok: 1'b1, done_err: 1'b0};
              remain_q     <= remain_nx;
              woff_q       <= woff_q + 16'(REC_LEN);
              cnt_q        <= '0;
              sum_q        <= '0;
              tx_byte_q    <= REPLY_OK;
              ret_q        <= (remain_nx == '0) ? ST_CMD : ST_DATA;
              state_q      <= ST_REPLY;
            end else begin
              cnt_q   <= cnt_q + 1'b1;
              state_q <= ST_PROG;
            end
          end
        end
        // erase the secondary area if allowed
        ST_ERASE: begin
          if (!may_write) begin
            cpu_slow_out <= 1'b0;
            status_out   <= '{busy: 1'b0, done_ok: 1'b0, done_err: 1'b1};
            tx_byte_q    <= REPLY_ER;
            ret_q        <= ST_CMD;
            state_q      <= ST_REPLY;
          end else begin
            flash_req_out.erase <= 1'b1;
            flash_req_out.addr  <= SEC_BASE;
            status_out          <= '{busy: 1'b1, done_ok: 1'b0, done_err: 1'b0};
            state_q             <= ST_EWAIT;
          end
        end
        // erase result, clock restored before reply
        ST_EWAIT: begin
          if (flash_done_in) begin
            cpu_slow_out <= 1'b0;
            status_out   <= '{busy: 1'b0, done_ok: ~flash_fail_in,
                              done_err: flash_fail_in};
            tx_byte_q    <= flash_fail_in ? REPLY_ER : REPLY_OK;
            ret_q        <= ST_CMD;
            state_q      <= ST_REPLY;
          end
        end
        // send one reply byte once the transmitter is free
        ST_REPLY: begin
          if (!tx_busy && !tx_start_q) begin
            tx_start_q <= 1'b1;
            state_q    <= ret_q;
          end
        end
        default: begin
          state_q <= ST_CMD;
        end
      endcase
    end
  end

endmodule : frm_monitor

// ===== test/frm_check_monitor.sv
// port-level assertions for the flash rewrite monitor
`timescale 1ns/1ps
module frm_check (
  input wire logic                          clk_in,
  input wire logic                          sys_rst_in,
  input wire logic                          rewrite_enable_bit_in,
  input wire logic                          secondary_lock_in,
  input wire logic [frm_pkg::ADDR_W-1:0]    cpu_addr_in,
  input wire logic                          periph_irq_in,
  input wire logic                          vector_in_ram_in,
  input wire logic                          handler_in_ram_in,
  input wire frm_pkg::frm_mode_t            mode_out,
  input wire frm_pkg::frm_flash_req_t       flash_req_out,
  input wire logic                          cpu_slow_out,
  input wire logic                          irq_take_out,
  input wire logic                          run_req_out,
  input wire logic                          data_flash_sel_out
);
  import frm_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // erase pulse: slowed clock, area base, gone next cycle
  sequence erase_tail;
    cpu_slow_out && flash_req_out.addr == SEC_BASE ##1 !flash_req_out.erase;
  endsequence
  // lock held long enough to be seen
  sequence held_lock;
    secondary_lock_in [*3];
  endsequence
  mode_follow_a: assert property (
    !$past(sys_rst_in) && !$past(sys_rst_in, 2) |-> mode_out.rewrite_mode == $past(rewrite_enable_bit_in, 2))
    else $error("rewrite mode mismatch");
  forced_bits_a: assert property (
    mode_out.rewrite_mode |-> mode_out.data_flash_enable && mode_out.expanded_space_bit)
    else $error("mode bits not forced");
  irq_gate_a: assert property (
    !$past(sys_rst_in) |-> irq_take_out == $past(periph_irq_in && vector_in_ram_in && handler_in_ram_in))
    else $error("irq gate wrong");
  prog_pulse_a: assert property (flash_req_out.prog |=> !flash_req_out.prog)
    else $error("prog not a pulse");
  prog_slow_a: assert property (flash_req_out.prog |-> cpu_slow_out && mode_out.rewrite_mode)
    else $error("prog without slow clock");
  erase_launch_a: assert property (flash_req_out.erase |-> erase_tail) else $error("erase launch wrong");
  lock_refuse_a: assert property (held_lock |-> !flash_req_out.prog && !flash_req_out.erase)
    else $error("locked area touched");
  run_pulse_a: assert property (run_req_out |=> !run_req_out) else $error("run not a pulse");
  dflash_map_a: assert property (
    data_flash_sel_out |-> $past(cpu_addr_in) inside {[DFLASH_LO:DFLASH_HI]})
    else $error("data flash decode wrong");
endmodule : frm_check
bind frm_monitor frm_check u_chk (.*);

// ===== test/frm_master.sv
// serial master model: sends characters, collects reply bytes
`timescale 1ns/1ps
module frm_master (
  input  wire logic clk_in,
  output logic      line_out,
  input  wire logic line_in,
  output logic [7:0] reply_out,
  output logic [7:0] count_out
);
  import frm_pkg::*;
  // one 8N1 frame, lsb first, idle high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in) line_out <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk_in);
    end
  endtask : send
  // receiver: mid-bit sampling after the start edge
  initial begin
    line_out  = 1'b1;
    count_out = 8'h00;
    forever begin
      @(negedge line_in);
      repeat (HALF_CYCLES + BIT_CYCLES) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        reply_out[i] = line_in;
        repeat (BIT_CYCLES) @(posedge clk_in);
      end
      count_out = count_out + 8'h01;
    end
  end
endmodule : frm_master

// ===== test/flash_rewrite_monitor_test.sv
// self-checking bench for the flash rewrite monitor
`timescale 1ns/1ps
module flash_rewrite_monitor_test;
  import frm_pkg::*;
  logic clk_in, sys_rst_in, serial_rx_in, serial_tx_out, rewrite_enable_bit_in, submode_write_unlock_in;
  logic submode_wr_in, pm_data_flash_in, pm_expanded_in, rom1_large_in, upper_rom_enable_in;
  logic secondary_rom_disable_in, secondary_lock_in, periph_irq_in, vector_in_ram_in, handler_in_ram_in;
  logic flash_done_in, flash_fail_in, cpu_slow_out, irq_take_out, run_req_out, data_flash_sel_out;
  logic [7:0]     submode_wdata_in, flash_submode_reg_out, reply, nrep;
  logic [19:0]    cpu_addr_in;
  logic [2:0]     dsr;
  frm_mode_t      mode_out;
  frm_status_t    status_out;
  frm_flash_req_t flash_req_out;
  logic           cpu_hold_out, upper_rom_sel_out, secondary_map_out;
  int             mismatches, cmp_count, nprog, nerase, nruns;
  frm_monitor u_dut (.*);
  frm_master u_master (.clk_in(clk_in), .line_out(serial_rx_in), .line_in(serial_tx_out),
                       .reply_out(reply), .count_out(nrep));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // sends n characters high first; optionally waits for one reply
  task automatic talk(input logic [63:0] s, input int n, input logic has_rep, input logic [7:0] exp);
    logic [7:0] n0;
    n0 = nrep;
    for (int i = n - 1; i >= 0; i--) u_master.send(s[8*i +: 8]);
    for (int i = 0; has_rep && i < 40000 && nrep == n0; i++) @(posedge clk_in);
    if (has_rep) chk({nrep, reply}, {n0 + 8'h01, exp});
  endtask : talk
  initial begin // clock
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // flash array stand-in: done four cycles after each pulse
  always @(posedge clk_in) begin
    dsr <= {dsr[1:0], flash_req_out.prog | flash_req_out.erase};
    flash_done_in <= dsr[2];
    if (run_req_out) nruns++;
    if (flash_req_out.erase) nerase++;
    if (flash_req_out.prog) begin
      chk({flash_req_out.addr, flash_req_out.data}, {SEC_BASE + 20'(nprog), nprog ? PAD_BYTE : 8'h5A});
      chk({cpu_slow_out, cpu_hold_out}, 2'b10);
      nprog++;
    end
  end
  initial begin // watchdog, run needs about 6.2 ms
    #8_000_000;
    mismatches++;
    wrap_up();
  end
  initial begin // main sequence
    {sys_rst_in, dsr} = 4'h8;
    {rewrite_enable_bit_in, submode_write_unlock_in, submode_wr_in, pm_data_flash_in, pm_expanded_in} = '0;
    {rom1_large_in, upper_rom_enable_in, secondary_rom_disable_in, secondary_lock_in, flash_fail_in} = '0;
    {periph_irq_in, vector_in_ram_in, handler_in_ram_in, flash_done_in, submode_wdata_in, cpu_addr_in} = '0;
    {mismatches, cmp_count, nprog, nerase, nruns} = '0;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in) rewrite_enable_bit_in <= 1'b1;
    @(posedge clk_in) submode_write_unlock_in <= 1'b1;
    @(posedge clk_in) {submode_wr_in, submode_wdata_in} <= 9'h102;
    @(posedge clk_in) submode_wr_in <= 1'b0;
    @(posedge clk_in) submode_write_unlock_in <= 1'b0;
    {rom1_large_in, upper_rom_enable_in, cpu_addr_in} <= {2'b11, 20'h0E010};
    {periph_irq_in, vector_in_ram_in, handler_in_ram_in} <= 3'b111;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    chk(flash_submode_reg_out, 8'h02);
    chk(mode_out, 4'hF);
    chk({irq_take_out, data_flash_sel_out, upper_rom_sel_out, secondary_map_out}, 4'hD);
    @(posedge clk_in) {handler_in_ram_in, cpu_addr_in} <= {1'b0, 20'h40010};
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(irq_take_out, 1'b0);
    chk({data_flash_sel_out, upper_rom_sel_out}, 2'b01);
    @(posedge clk_in) secondary_lock_in <= 1'b1;
    talk(64'(CMD_ERS), 3, 1'b1, REPLY_ER);
    chk({status_out, 8'(nerase)}, {3'b001, 8'h00});
    @(posedge clk_in) secondary_lock_in <= 1'b0;
    talk(64'(CMD_ERS), 3, 1'b1, REPLY_OK);
    chk({status_out, cpu_slow_out, 8'(nerase)}, {3'b010, 1'b0, 8'h01});
    talk({CMD_PRG, 16'h0001, 8'h5A, 16'h005A}, 8, 1'b1, REPLY_OK);
    chk({status_out, cpu_slow_out}, 4'h4);
    chk(nprog, 256);
    talk(64'h78797A, 3, 1'b1, REPLY_ER);
    talk(64'(CMD_RUN), 3, 1'b0, 8'h00);
    repeat (4) @(posedge clk_in);
    chk(nruns, 1);
    wrap_up();
  end
endmodule : flash_rewrite_monitor_test
